// ---- hdl/clock_gating_pll_translation.sv ----
// Clock gating control and crystal to PLL translation with APB access
// Notes on behaviour
// - PLL translation loaded from crystal selection on the first clock after reset
// - PLL translation recomputed whenever the crystal selection changes
// - Bits 15:14 hold output divide driven to the PLL
// - Bits 13:5 hold multiplier driven to the PLL feedback input
// - Bits 4:0 hold input divide driven to the PLL reference
// - Each gating bit is one unit clock enable
// - Access to an unclocked unit gives a bus fault
// - Gating bits reset to zero unless stated otherwise
// - Separate gating registers for run, sleep and deep sleep
// - Sleep gating applies only with automatic clock gating set
// - Bit 20 gates the pulse-width unit, reset zero
// - Bit 16 gates the converter, reset one
// - Bits 11:8 of the run gating register pick converter sample rate in every mode, reset 0x2
// - Bit 3 gates the watchdog, reset zero
// - Bit 2 gates trace output, bit 1 serial debug, reset zero
// - Bit 0 gates JTAG, reset one
// - Crystal selection sits in bits 9:6, reset 0xB
//
// The APB register port was chosen for this implementation.
`include "clk_gate_defs.svh"

module clock_gating_pll_translation
    import clk_gate_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_req,
    input  wire logic        deepsleep_req,
    input  wire unit_gates_t unit_access,
    output unit_gates_t      unit_clk_en,
    output logic      [3:0]  converter_rate_limit,
    output pll_setting_t     pll_setting,
    output logic             unit_bus_fault
);

    // ******************************
    // Helper functions
    // ******************************

    // Crystal code to PLL fields; reserved codes give zero
    function automatic logic [15:0] crystal_to_pll_table(
        input logic [3:0] crystal_select
    );
        logic [15:0] v;
        v = 16'h0000;
        if (crystal_select >= `CRYSTAL_SELECT_FIRST_OK) begin
            v[15:14] = `PLL_OD_VALUE;
            v[13:5]  = `PLL_F_BASE + {5'h00, crystal_select};
            v[4:0]   = {1'b0, crystal_select} - 5'h01;
        end
        return v;
    endfunction

    // Gating register word to unit enables
    function automatic unit_gates_t gate_fields(input logic [31:0] w);
        unit_gates_t g;
        g.pwm       = w[`GATE_PWM_BIT];
        g.converter = w[`GATE_CONV_BIT];
        g.watchdog  = w[`GATE_WDOG_BIT];
        g.trace     = w[`GATE_TRACE_BIT];
        g.swd       = w[`GATE_SWD_BIT];
        g.jtag      = w[`GATE_JTAG_BIT];
        return g;
    endfunction

    // Masked write of a register word
    function automatic logic [31:0] masked_write(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [31:0] mask
    );
        return (old & ~mask) | (wdata & mask);
    endfunction

    // ******************************
    // Registers
    // ******************************
    logic [31:0] config_reg;
    logic [31:0] config_next;
    logic [31:0] run_gate_reg;
    logic [31:0] run_gate_next;
    logic [31:0] sleep_gate_reg;
    logic [31:0] sleep_gate_next;
    logic [31:0] deep_gate_reg;
    logic [31:0] deep_gate_next;
    logic [15:0] pll_reg;
    logic [15:0] pll_next;
    logic        loaded_reg;
    logic        loaded_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        setup;
    logic        wr_en;
    logic        hit;
    power_mode_t mode;
    logic [31:0] active_gate;

    // ******************************
    // APB decode
    // ******************************

    // Zero wait states; access phase always completes
    assign setup  = psel & ~penable;
    assign wr_en  = psel & penable & pwrite;
    assign pready = 1'b1;

    // Address hit check
    always_comb begin
        if (paddr == `OFS_RUN_CLOCK_CONFIG) begin
            hit = 1'b1;
        end else if (paddr == `OFS_PLL_TRANSLATION) begin
            hit = 1'b1;
        end else if (paddr == `OFS_RUN_GATE) begin
            hit = 1'b1;
        end else if (paddr == `OFS_SLEEP_GATE) begin
            hit = 1'b1;
        end else if (paddr == `OFS_DEEPSLEEP_GATE) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // Unmapped addresses answer with an error
    assign pslverr = psel & penable & ~hit;

    // Read data captured in the setup cycle; reserved bits read zero
    always_comb begin
        rdata_next = rdata_reg;
        if (setup) begin
            if (paddr == `OFS_RUN_CLOCK_CONFIG) begin
                rdata_next = config_reg;
            end else if (paddr == `OFS_PLL_TRANSLATION) begin
                rdata_next = {16'h0000, pll_reg};
            end else if (paddr == `OFS_RUN_GATE) begin
                rdata_next = run_gate_reg;
            end else if (paddr == `OFS_SLEEP_GATE) begin
                rdata_next = sleep_gate_reg;
            end else if (paddr == `OFS_DEEPSLEEP_GATE) begin
                rdata_next = deep_gate_reg;
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    // ******************************
    // Register writes
    // ******************************

    // Masked writes keep read-only bits; PLL word ignores writes
    always_comb begin
        config_next     = config_reg;
        run_gate_next   = run_gate_reg;
        sleep_gate_next = sleep_gate_reg;
        deep_gate_next  = deep_gate_reg;
        if (wr_en) begin
            if (paddr == `OFS_RUN_CLOCK_CONFIG) begin
                config_next = masked_write(config_reg, pwdata,
                                           `CFG_WMASK);
            end else if (paddr == `OFS_RUN_GATE) begin
                run_gate_next = masked_write(run_gate_reg, pwdata,
                                             `GATE_WMASK);
            end else if (paddr == `OFS_SLEEP_GATE) begin
                sleep_gate_next = masked_write(sleep_gate_reg, pwdata,
                                               `GATE_WMASK);
            end else if (paddr == `OFS_DEEPSLEEP_GATE) begin
                deep_gate_next = masked_write(deep_gate_reg, pwdata,
                                              `GATE_WMASK);
            end
        end
    end

    // ******************************
    // PLL translation
    // ******************************

    // Loaded once after reset, then follows the crystal field
    always_comb begin
        loaded_next = 1'b1;
        pll_next    = crystal_to_pll_table(
            config_reg[`CFG_CRYSTAL_SELECT_MSB:`CFG_CRYSTAL_SELECT_LSB]);
    end

    // PLL fields driven out from the stored word
    assign pll_setting.od = pll_reg[15:14];
    assign pll_setting.fb = pll_reg[13:5];
    assign pll_setting.rd = pll_reg[4:0];

    // ******************************
    // Gating selection
    // ******************************

    // Sleep tables used only under automatic gating
    always_comb begin
        if (!config_reg[`CFG_ACG_BIT]) begin
            mode = MODE_RUN;
        end else if (deepsleep_req) begin
            mode = MODE_DEEPSLEEP;
        end else if (sleep_req) begin
            mode = MODE_SLEEP;
        end else begin
            mode = MODE_RUN;
        end
    end

    // Gating word in force for the current mode
    always_comb begin
        case (mode)
            MODE_SLEEP:     active_gate = sleep_gate_reg;
            MODE_DEEPSLEEP: active_gate = deep_gate_reg;
            default:        active_gate = run_gate_reg;
        endcase
    end

    // Unit clock enables and rate field
    assign unit_clk_en = gate_fields(active_gate);
    assign converter_rate_limit =
        run_gate_reg[`GATE_RATE_MSB:`GATE_RATE_LSB];

    // Any access to a stopped unit faults
    assign unit_bus_fault = |(unit_access & ~unit_clk_en);

    // ******************************
    // State registers
    // ******************************

    // Gating reset values hold converter and JTAG enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg     <= `CFG_RESET;
            run_gate_reg   <= `GATE_RESET;
            sleep_gate_reg <= `GATE_RESET;
            deep_gate_reg  <= `GATE_RESET;
            pll_reg        <= 16'h0000;
            loaded_reg     <= 1'b0;
            rdata_reg      <= 32'h0000_0000;
        end else begin
            config_reg     <= config_next;
            run_gate_reg   <= run_gate_next;
            sleep_gate_reg <= sleep_gate_next;
            deep_gate_reg  <= deep_gate_next;
            pll_reg        <= pll_next;
            loaded_reg     <= loaded_next;
            rdata_reg      <= rdata_next;
        end
    end

    assign prdata = rdata_reg;

    // ******************************
    // Assertions
    // ******************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_crystal_select_change;
        $changed(config_reg[`CFG_CRYSTAL_SELECT_MSB:`CFG_CRYSTAL_SELECT_LSB]);
    endsequence

    property p_pll_load;
        $rose(loaded_reg) |-> pll_reg == crystal_to_pll_table(
            config_reg[`CFG_CRYSTAL_SELECT_MSB:`CFG_CRYSTAL_SELECT_LSB]);
    endproperty
    a_pll_load: assert property (p_pll_load)
        else $error("PLL word not loaded after reset");

    property p_pll_follow;
        s_crystal_select_change ##1 1'b1 |-> pll_reg == crystal_to_pll_table(
            $past(config_reg[`CFG_CRYSTAL_SELECT_MSB:`CFG_CRYSTAL_SELECT_LSB]));
    endproperty
    a_pll_follow: assert property (p_pll_follow)
        else $error("PLL word missed crystal change");

    property p_pll_ro;
        wr_en && paddr == `OFS_PLL_TRANSLATION && loaded_reg
            && !$changed(config_reg) |=> $stable(pll_reg);
    endproperty
    a_pll_ro: assert property (p_pll_ro)
        else $error("PLL word changed by a write");

    property p_fault;
        (unit_access.jtag && !unit_clk_en.jtag) |-> unit_bus_fault;
    endproperty
    a_fault: assert property (p_fault)
        else $error("No fault on stopped unit");

    property p_no_fault;
        (unit_access & ~unit_clk_en) == '0 |-> !unit_bus_fault;
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("Fault on running unit");

    property p_run_only;
        !config_reg[`CFG_ACG_BIT] |-> unit_clk_en
            == gate_fields(run_gate_reg);
    endproperty
    a_run_only: assert property (p_run_only)
        else $error("Sleep gating used without auto gating");

    property p_deep;
        config_reg[`CFG_ACG_BIT] && deepsleep_req |-> unit_clk_en
            == gate_fields(deep_gate_reg);
    endproperty
    a_deep: assert property (p_deep)
        else $error("Deep sleep gating not applied");

    property p_sleep;
        config_reg[`CFG_ACG_BIT] && sleep_req && !deepsleep_req |->
            unit_clk_en == gate_fields(sleep_gate_reg);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("Sleep gating not applied");

    property p_reserved;
        wr_en && paddr == `OFS_RUN_GATE |=>
            (run_gate_reg & ~`GATE_WMASK)
            == (`GATE_RESET & ~`GATE_WMASK);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("Reserved gating bits written");

    property p_rate;
        wr_en && paddr == `OFS_RUN_GATE |=> converter_rate_limit
            == $past(pwdata[`GATE_RATE_MSB:`GATE_RATE_LSB]);
    endproperty
    a_rate: assert property (p_rate)
        else $error("Rate field not written");

endmodule

// ---- hdl/clk_gate_defs.svh ----
// Offsets, field positions, reset values and masks of the clock block
`ifndef CLK_GATE_DEFS_SVH
`define CLK_GATE_DEFS_SVH

// ******************************
// Register byte addresses
// ******************************
`define OFS_RUN_CLOCK_CONFIG 12'h0f0
`define OFS_PLL_TRANSLATION  12'h064
`define OFS_RUN_GATE         12'h100
`define OFS_SLEEP_GATE       12'h110
`define OFS_DEEPSLEEP_GATE   12'h120

// ******************************
// Field positions
// ******************************
`define CFG_CRYSTAL_SELECT_LSB   6
`define CFG_CRYSTAL_SELECT_MSB   9
`define CFG_ACG_BIT    27
`define PLL_OD_LSB     14
`define PLL_F_LSB      5
`define GATE_PWM_BIT   20
`define GATE_CONV_BIT  16
`define GATE_RATE_LSB  8
`define GATE_RATE_MSB  11
`define GATE_WDOG_BIT  3
`define GATE_TRACE_BIT 2
`define GATE_SWD_BIT   1
`define GATE_JTAG_BIT  0

// ******************************
// Reset values, write masks and PLL translation constants
// ******************************
`define CFG_RESET      32'h0000_02c0
`define CFG_WMASK      32'h0800_03c0
`define GATE_RESET     32'h0001_0201
`define GATE_WMASK     32'h0011_0f0f
`define CRYSTAL_SELECT_FIRST_OK  4'h4
`define PLL_OD_VALUE   2'h0
`define PLL_F_BASE     9'h020

`endif

// ---- hdl/clk_gate_pkg.sv ----
// Types shared by the clock gating and PLL translation block
package clk_gate_pkg;

    // One clock enable for each gated unit
    typedef struct packed {
        logic pwm;
        logic converter;
        logic watchdog;
        logic trace;
        logic swd;
        logic jtag;
    } unit_gates_t;

    // Power mode selecting the gating register in force
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEPSLEEP
    } power_mode_t;

    // Fields handed to the PLL
    typedef struct packed {
        logic [1:0] od;
        logic [8:0] fb;
        logic [4:0] rd;
    } pll_setting_t;

endpackage

// ---- testbench/clock_gating_pll_translation_tb.sv ----
// Self-checking testbench of the clock gating and PLL translation block
`include "clk_gate_defs.svh"

module clock_gating_pll_translation_tb
    import clk_gate_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************
    // Signals
    // ********************************
    logic         clk;
    logic         rst_n;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic  [11:0] paddr;
    logic  [31:0] pwdata;
    logic  [31:0] prdata;
    logic         pready;
    logic         pslverr;
    logic         sleep_req;
    logic         deepsleep_req;
    unit_gates_t  unit_access;
    unit_gates_t  unit_clk_en;
    logic  [3:0]  converter_rate_limit;
    pll_setting_t pll_setting;
    logic         unit_bus_fault;
    int           n_mismatch;
    int           num_checks;

    clock_gating_pll_translation u_dut (
        .clk                  (clk),
        .rst_n                (rst_n),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .sleep_req            (sleep_req),
        .deepsleep_req        (deepsleep_req),
        .unit_access          (unit_access),
        .unit_clk_en          (unit_clk_en),
        .converter_rate_limit (converter_rate_limit),
        .pll_setting          (pll_setting),
        .unit_bus_fault       (unit_bus_fault)
    );

    // ********************************
    // Helpers
    // ********************************
    // Clock of 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Expected PLL fields for a crystal code
    function automatic logic [15:0] pll_of(input logic [3:0] code);
        logic [15:0] v;
        v = 16'h0000;
        if (code > 4'h3) begin
            v = {2'h0, 9'h020 + {5'h00, code}, {1'b0, code - 4'h1}};
        end
        return v;
    endfunction

    task automatic close_out;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer, holding the request until pready
    task automatic apb(input logic wr_en, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            close_out();
        end else begin
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk("write error", 32'h0, {31'h0, e});
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a,
                          input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, x, r);
        chk("read error", 32'h0, {31'h0, e});
    endtask

    // Drive unit accesses and let the outputs settle
    task automatic probe(input logic [5:0] acc);
        @(posedge clk);
        unit_access <= unit_gates_t'(acc);
        @(negedge clk);
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset;
        probe(6'h00);
        chk("enables", 32'h11, 32'(unit_clk_en));
        chk("rate", 32'h2, 32'(converter_rate_limit));
        chk("pll pins", 32'(pll_of(4'hb)), 32'(pll_setting));
        rd_chk("run gate", `OFS_RUN_GATE, 32'h0001_0201);
        rd_chk("sleep gate", `OFS_SLEEP_GATE, 32'h0001_0201);
        rd_chk("deep gate", `OFS_DEEPSLEEP_GATE, 32'h0001_0201);
        rd_chk("pll", `OFS_PLL_TRANSLATION, 32'(pll_of(4'hb)));
        rd_chk("config", `OFS_RUN_CLOCK_CONFIG, 32'h0000_02c0);
    endtask

    task automatic t_gates;
        int          pos[6] = '{0, 1, 2, 3, 16, 20};
        logic [31:0] d;
        for (int r = 0; r < 3; r++) begin
            d = 32'hffff_f0ff | (32'(r) << 8);
            wr(`OFS_RUN_GATE, d);
            rd_chk("masked", `OFS_RUN_GATE, d & 32'h0011_0f0f);
            probe(6'h3f);
            chk("all on", 32'h3f, 32'(unit_clk_en));
            chk("no fault", 32'h0, 32'(unit_bus_fault));
            chk("rate", 32'(r), 32'(converter_rate_limit));
        end
        // One unit clocked at a time, an access to all others together must fault
        for (int b = 0; b < 6; b++) begin
            wr(`OFS_RUN_GATE, 32'h1 << pos[b]);
            probe(6'h01 << b);
            chk("one on", 32'h1 << b, 32'(unit_clk_en));
            chk("own ok", 32'h0, 32'(unit_bus_fault));
            probe(~(6'h01 << b));
            chk("gated", 32'h1, 32'(unit_bus_fault));
        end
        probe(6'h00);
    endtask

    task automatic t_pll;
        logic [15:0] e;
        for (int c = 0; c < 16; c++) begin
            wr(`OFS_RUN_CLOCK_CONFIG, 32'(c) << 6);
            @(posedge clk);
            @(negedge clk);
            e = pll_of(4'(c));
            chk("od", 32'(e[15:14]), 32'(pll_setting.od));
            chk("fb", 32'(e[13:5]), 32'(pll_setting.fb));
            chk("rd", 32'(e[4:0]), 32'(pll_setting.rd));
            rd_chk("pll reg", `OFS_PLL_TRANSLATION, {16'h0, e});
        end
        wr(`OFS_PLL_TRANSLATION, 32'hffff_ffff);
        rd_chk("pll ro", `OFS_PLL_TRANSLATION, {16'h0, e});
    endtask

    task automatic t_modes;
        wr(`OFS_RUN_GATE, 32'h0000_0001);
        wr(`OFS_SLEEP_GATE, 32'h0000_0008);
        wr(`OFS_DEEPSLEEP_GATE, 32'h0010_0000);
        @(posedge clk);
        sleep_req <= 1'b1;
        @(negedge clk);
        chk("no auto", 32'h01, 32'(unit_clk_en));
        wr(`OFS_RUN_CLOCK_CONFIG, 32'h0800_02c0);
        probe(6'h00);
        chk("sleep set", 32'h08, 32'(unit_clk_en));
        @(posedge clk);
        deepsleep_req <= 1'b1;
        @(negedge clk);
        chk("deep set", 32'h20, 32'(unit_clk_en));
        @(posedge clk);
        sleep_req     <= 1'b0;
        deepsleep_req <= 1'b0;
        @(negedge clk);
        chk("run set", 32'h01, 32'(unit_clk_en));
    endtask

    task automatic t_unmapped;
        logic [31:0] r;
        logic        e;
        apb(1'b1, 12'h104, 32'hffff_ffff, r, e);
        chk("bad write", 32'h1, {31'h0, e});
        apb(1'b0, 12'h0f4, 32'h0, r, e);
        chk("bad read", 32'h1, {31'h0, e});
        chk("bad data", 32'h0, r);
        rd_chk("kept", `OFS_RUN_GATE, 32'h0000_0001);
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        rst_n         = 1'b0;
        psel          = 1'b0;
        penable       = 1'b0;
        pwrite        = 1'b0;
        paddr         = 12'h000;
        pwdata        = 32'h0;
        sleep_req     = 1'b0;
        deepsleep_req = 1'b0;
        unit_access   = '0;
        n_mismatch    = 0;
        num_checks    = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_gates();
        t_pll();
        t_modes();
        t_unmapped();
        close_out();
    end

endmodule
